// File: src/adc_port_pkg.sv
// Shared constants, carrier types and checksum arithmetic for the ADC serial port
package adc_port_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         CLK_NS     = 10;
    localparam int         CONV_NS    = 190;
    // Least time: round up to whole cycles
    localparam int         CONV_CYC   = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] CONV_LAST  = 8'(CONV_CYC - 1);

    // ------------------------------------------------------------------
    // Command frame layout
    // ------------------------------------------------------------------
    localparam int         CMD_WR_BIT = 15;
    localparam int         CMD_AD_LSB = 12;
    localparam logic [4:0] CMD_LEN    = 5'h10;
    localparam logic [4:0] CMD_CRC_LEN = 5'h18;
    localparam logic [6:0] REG_CRC_BITS = 7'h10;
    localparam logic [6:0] CONV_BITS    = 7'h40;
    localparam logic [6:0] BOOST_BITS   = 7'h48;
    localparam logic [7:0] CRC_POLY     = 8'h07;

    // ------------------------------------------------------------------
    // Register addresses, fields and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  ADDR_CFG1  = 3'h1;
    localparam logic [2:0]  ADDR_CFG2  = 3'h2;
    localparam logic [2:0]  ADDR_FLAGS = 3'h3;
    localparam logic [2:0]  ADDR_LOW   = 3'h4;
    localparam logic [2:0]  ADDR_HIGH  = 3'h5;
    localparam int          CFG1_CRC_W = 5;
    localparam int          CFG1_CRC_R = 4;
    localparam int          CFG1_RES   = 2;
    localparam int          CFG2_LANE_LSB = 8;
    localparam logic [11:0] CFG1_MASK  = 12'h3ff;
    localparam logic [11:0] CFG1_RST   = 12'h000;
    localparam logic [11:0] CFG2_RST   = 12'h000;
    localparam logic [11:0] LOW_RST    = 12'h800;
    localparam logic [11:0] HIGH_RST   = 12'h7ff;

    localparam logic [1:0]  LANES_DUAL = 2'h0;
    localparam logic [1:0]  LANES_ONE  = 2'h1;
    localparam logic [1:0]  LANES_QUAD = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic serial_out_a;
        logic serial_out_b;
        logic serial_out_c;
        logic serial_out_d_or_range_flag;
    } lanes_t;

    typedef struct packed {
        logic [17:0] a;
        logic [17:0] b;
        logic [17:0] c;
        logic [17:0] d;
    } results_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } spi_pins_t;

    localparam spi_pins_t PINS_IDLE = 3'h4;
    localparam lanes_t    LANES_OFF = 4'hf;

    // Checksum over the top n bits of d, top byte inverted, x^8+x^2+x+1
    function automatic logic [7:0] crc8(input logic [79:0] d, input logic [6:0] n);
        logic [79:0] v;
        logic [7:0]  c;
        v = d ^ {8'hff, 72'h0};
        c = 8'h00;
        for (int i = 79; i >= 0; i--) begin
            if (i >= 80 - int'(n)) begin
                c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
            end
        end
        return c;
    endfunction

endpackage

// File: src/pin_sync.sv
// Two-stage pin synchroniser with edge pulses for the serial port pins
`timescale 1ns/1ps
module pin_sync import adc_port_pkg::*; (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire spi_pins_t raw,
    output spi_pins_t      level,
    output spi_pins_t      rise,
    output spi_pins_t      fall
);
    spi_pins_t meta;
    spi_pins_t stage;
    spi_pins_t prev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta  <= PINS_IDLE;
            stage <= PINS_IDLE;
            prev  <= PINS_IDLE;
        end else begin
            meta  <= raw;
            stage <= meta;
            prev  <= stage;
        end
    end

    assign level = stage;
    assign rise  = stage & ~prev;
    assign fall  = ~stage & prev;
endmodule // pin_sync

// File: src/quad_adc_serial_port_crc.sv
// Serial port of a quad sampling converter: lane routing, registers, checksums
`timescale 1ns/1ps
module quad_adc_serial_port_crc import adc_port_pkg::*; (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire spi_pins_t pins,
    input  wire results_t  conversion_result,
    input  wire logic [11:0] range_flags,
    output logic           conv_start,
    output lanes_t         lanes,
    output lanes_t         lanes_oe_n,
    output logic [11:0]    first_config_register,
    output logic [11:0]    second_config_register
);
    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    spi_pins_t lvl;
    spi_pins_t rise;
    spi_pins_t fall;
    logic      load;
    logic      close;
    logic      open;

    pin_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (pins),
        .level (lvl),
        .rise  (rise),
        .fall  (fall)
    );

    assign load  = fall.cs_n;
    assign close = rise.cs_n;
    assign open  = !lvl.cs_n;

    logic [1:0] lane_mode;
    logic       crc_w;
    logic       crc_r;
    logic       boost;

    assign lane_mode = second_config_register[CFG2_LANE_LSB +: 2];
    assign crc_w     = first_config_register[CFG1_CRC_W];
    assign crc_r     = first_config_register[CFG1_CRC_R];
    assign boost     = first_config_register[CFG1_RES];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    logic       busy;
    logic [7:0] conv_cnt;
    results_t   held;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= load;
        end
    end

    // A frame that starts mid-conversion restarts it; the old result stays
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy     <= 1'b0;
            conv_cnt <= 8'h00;
            held     <= '0;
        end else if (load) begin
            busy     <= 1'b1;
            conv_cnt <= CONV_LAST;
        end else if (busy) begin
            if (conv_cnt == 8'h00) begin
                busy <= 1'b0;
                held <= conversion_result;
            end else begin
                conv_cnt <= conv_cnt - 8'h01;
            end
        end
    end

    a_conv_span: assert property (load |=> busy [*8])
        else $error("conversion ended too early");
    a_conv_done: assert property (busy && conv_cnt == 8'h00 && !load
        |=> !busy && held == $past(conversion_result))
        else $error("result not captured at conversion end");

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    logic [23:0] rx;
    logic [4:0]  rx_cnt;
    logic [23:0] rx_al;
    logic [15:0] cmd;
    logic        cmd_ok;
    logic        crc_ok;
    logic        enabling;
    logic        wr_ok;
    logic [2:0]  addr;

    // Only the first 24 bits count; later clocks in longer frames only shift data out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx     <= 24'h0000;
            rx_cnt <= 5'h00;
        end else if (load) begin
            rx     <= 24'h0000;
            rx_cnt <= 5'h00;
        end else if (open && fall.sclk && rx_cnt != CMD_CRC_LEN) begin
            rx     <= {rx[22:0], lvl.sdi};
            rx_cnt <= rx_cnt + 5'h01;
        end
    end

    always_comb begin
        rx_al    = rx >> (rx_cnt - CMD_LEN);
        cmd      = rx_al[15:0];
        addr     = cmd[CMD_AD_LSB +: 3];
        cmd_ok   = rx_cnt >= CMD_LEN;
        crc_ok   = (rx_cnt == CMD_CRC_LEN)
                 && crc8({cmd, 64'h0}, REG_CRC_BITS) == rx[7:0];
        enabling = addr == ADDR_CFG1 && cmd[CFG1_CRC_W] && !crc_w;
        // Once checking is on, clearing it needs the checksum too
        wr_ok    = cmd_ok && cmd[CMD_WR_BIT]
                 && ((crc_w || enabling) ? crc_ok : 1'b1);
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [11:0] low_limit;
    logic [11:0] high_limit;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_config_register  <= CFG1_RST;
            second_config_register <= CFG2_RST;
            low_limit              <= LOW_RST;
            high_limit             <= HIGH_RST;
        end else if (close && wr_ok) begin
            if (addr == ADDR_CFG1) begin
                first_config_register <= cmd[11:0] & CFG1_MASK;
            end else if (addr == ADDR_CFG2) begin
                second_config_register <= cmd[11:0];
            end else if (addr == ADDR_LOW) begin
                low_limit <= cmd[11:0];
            end else if (addr == ADDR_HIGH) begin
                high_limit <= cmd[11:0];
            end
        end
    end

    a_write_store: assert property (close && wr_ok && addr == ADDR_CFG2
        |=> second_config_register == $past(cmd[11:0]))
        else $error("accepted write not stored");
    a_crc_guard: assert property (close && crc_w && !crc_ok
        |=> $stable(first_config_register) && $stable(second_config_register))
        else $error("unchecked write changed a register");
    a_enable_guard: assert property (close && enabling && !crc_ok
        |=> !crc_w)
        else $error("write check enabled without checksum");

    // ------------------------------------------------------------------
    // Pending register read
    // ------------------------------------------------------------------
    logic        pend;
    logic [2:0]  rd_addr;
    logic [11:0] rd_data;
    logic [15:0] rd_word;
    logic [7:0]  reg_crc;

    // Serves exactly the frame after the read command
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend    <= 1'b0;
            rd_addr <= 3'h0;
        end else if (close) begin
            pend    <= cmd_ok && !cmd[CMD_WR_BIT] && addr != 3'h0
                    && addr < 3'h6;
            rd_addr <= addr;
        end
    end

    always_comb begin
        rd_data = 12'h000;
        if (rd_addr == ADDR_CFG1) begin
            rd_data = first_config_register;
        end else if (rd_addr == ADDR_CFG2) begin
            rd_data = second_config_register;
        end else if (rd_addr == ADDR_FLAGS) begin
            rd_data = range_flags;
        end else if (rd_addr == ADDR_LOW) begin
            rd_data = low_limit;
        end else if (rd_addr == ADDR_HIGH) begin
            rd_data = high_limit;
        end
        rd_word = {1'b0, rd_addr, rd_data};
        reg_crc = crc8({rd_word, 64'h0}, REG_CRC_BITS);
    end

    a_nop_read: assert property (close && cmd_ok && !cmd[CMD_WR_BIT]
        && (addr == 3'h0 || addr >= 3'h6) |=> !pend)
        else $error("no-op read left a register read pending");

    // ------------------------------------------------------------------
    // Transmit images
    // ------------------------------------------------------------------
    // Packs n channels (16 or 18 bits each) then an optional checksum, MSB aligned
    function automatic logic [79:0] pack(input logic [3:0][17:0] ch, input int n,
                                         input logic bst, input logic [7:0] crc,
                                         input logic add_crc);
        logic [79:0] acc;
        int          w;
        acc = 80'h0;
        w   = 0;
        for (int j = 0; j < 4; j++) begin
            if (j < n) begin
                if (bst) begin
                    acc = {acc[61:0], ch[j]};
                    w   = w + 18;
                end else begin
                    acc = {acc[63:0], ch[j][17:2]};
                    w   = w + 16;
                end
            end
        end
        if (add_crc) begin
            acc = {acc[71:0], crc};
            w   = w + 8;
        end
        return acc << (80 - w);
    endfunction

    logic [3:0][17:0] all_ch;
    logic [79:0]      img [4];
    logic [79:0]      sh  [4];
    logic [7:0]       conv_crc;

    always_comb begin
        all_ch   = {held.d, held.c, held.b, held.a};
        conv_crc = crc8(pack(all_ch, 4, boost, 8'h00, 1'b0),
                        boost ? BOOST_BITS : CONV_BITS);
        for (int k = 0; k < 4; k++) begin
            img[k] = 80'h0;
        end
        if (pend) begin
            img[0] = crc_r ? {rd_word, reg_crc, 56'h0} : {rd_word, 64'h0};
        end else if (lane_mode == LANES_QUAD) begin
            img[0] = pack({54'h0, held.a}, 1, boost, conv_crc, crc_r);
            img[1] = pack({54'h0, held.b}, 1, boost, 8'h00, 1'b0);
            img[2] = pack({54'h0, held.c}, 1, boost, 8'h00, 1'b0);
            img[3] = pack({54'h0, held.d}, 1, boost, 8'h00, 1'b0);
        end else if (lane_mode == LANES_DUAL) begin
            img[0] = pack({36'h0, held.c, held.a}, 2, boost, conv_crc, crc_r);
            img[1] = pack({36'h0, held.d, held.b}, 2, boost, 8'h00, 1'b0);
        end else begin
            img[0] = pack(all_ch, 4, boost, conv_crc, crc_r);
        end
    end

    // ------------------------------------------------------------------
    // Shift out and lane drive
    // ------------------------------------------------------------------
    logic drive;

    // Latest finished result, or the pending register word, loads at select fall, MSB first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int k = 0; k < 4; k++) begin
                sh[k] <= 80'h0;
            end
        end else if (load) begin
            for (int k = 0; k < 4; k++) begin
                sh[k] <= img[k];
            end
        end else if (open && rise.sclk) begin
            for (int k = 0; k < 4; k++) begin
                sh[k] <= {sh[k][78:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive <= 1'b0;
        end else if (load) begin
            drive <= 1'b1;
        end else if (close) begin
            drive <= 1'b0;
        end
    end

    assign lanes.serial_out_a               = sh[0][79];
    assign lanes.serial_out_b               = sh[1][79];
    assign lanes.serial_out_c               = sh[2][79];
    assign lanes.serial_out_d_or_range_flag = sh[3][79];

    // Lanes outside the selected lane mode stay released so the shared range pin is free
    assign lanes_oe_n.serial_out_a = !drive;
    assign lanes_oe_n.serial_out_b = !drive || lane_mode == LANES_ONE
                                   || lane_mode == 2'h3;
    assign lanes_oe_n.serial_out_c = !drive || lane_mode != LANES_QUAD;
    assign lanes_oe_n.serial_out_d_or_range_flag = !drive || lane_mode != LANES_QUAD;

    a_lane_release: assert property (close |=> lanes_oe_n == LANES_OFF)
        else $error("lanes still driven after select rose");
    a_quad_lane_map: assert property (load && !pend && lane_mode == LANES_QUAD
        |=> lanes.serial_out_b == $past(held.b[17])
            && lanes.serial_out_d_or_range_flag == $past(held.d[17]))
        else $error("quad lane carries wrong channel");
    a_dual_lane_map: assert property (load && !pend && lane_mode == LANES_DUAL
        |=> lanes.serial_out_a == $past(held.a[17])
            && lanes.serial_out_b == $past(held.b[17]))
        else $error("dual lane carries wrong channel");

    sequence s_single_load;
        load && !pend && !boost && lane_mode == LANES_ONE;
    endsequence
    a_single_order: assert property (s_single_load
        |=> sh[0][79:64] == $past(held.a[17:2]) && sh[0][63:48] == $past(held.b[17:2])
            && sh[0][31:16] == $past(held.d[17:2]))
        else $error("single lane order wrong");

    sequence s_reg_load;
        load && pend;
    endsequence
    a_reg_readout: assert property (s_reg_load
        |=> sh[0][79:64] == $past(rd_word) && sh[1] == 80'h0)
        else $error("register data not presented");
    a_crc_tail: assert property (load && !pend && crc_r && !boost
        && lane_mode == LANES_QUAD |=> sh[0][63:56] == $past(conv_crc))
        else $error("checksum not behind lane a data");

endmodule // quad_adc_serial_port_crc

// File: verif/host_spi_model.sv
// Host serial controller model: frames, serial clock, command bits, lane capture
`timescale 1ns/1ps
module host_spi_model import adc_port_pkg::*; (
    output spi_pins_t   pins,
    input  wire lanes_t lanes
);
    initial pins = PINS_IDLE;

    // ------------------------------------------------------------------
    // One framed transfer of n serial clocks
    // ------------------------------------------------------------------
    task automatic xfer(input logic [23:0] tx, input int n,
                        output logic [79:0] ra, output logic [79:0] rb,
                        output logic [79:0] rc, output logic [79:0] rd);
        ra = '0;
        rb = '0;
        rc = '0;
        rd = '0;
        pins.cs_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            // Capture before the rising edge moves the lanes on
            ra = {ra[78:0], lanes.serial_out_a};
            rb = {rb[78:0], lanes.serial_out_b};
            rc = {rc[78:0], lanes.serial_out_c};
            rd = {rd[78:0], lanes.serial_out_d_or_range_flag};
            pins.sclk = 1'b1;
            // Command MSB first; past 24 bits the line just toggles
            pins.sdi = (i < 24) ? tx[23 - i] : ~pins.sdi;
            #62.5;
            pins.sclk = 1'b0;
            #62.5;
        end
        #60;
        pins.cs_n = 1'b1;
        // Released line: no stale level left behind
        pins.sdi = ~pins.sdi;
    endtask
endmodule // host_spi_model

// File: verif/tb_quad_adc_serial_port_crc.sv
// Self-checking bench for the quad converter serial port
`timescale 1ns/1ps
module tb_quad_adc_serial_port_crc import adc_port_pkg::*; ;
    typedef struct {logic [1:0] mode; logic cr; logic bst; int n;} row_t;
    typedef struct {logic [2:0] ad; logic [11:0] dat; logic [1:0] kind;
                    logic [11:0] c1; logic [11:0] c2;} wc_t;
    logic        clk;
    logic        rst_n;
    spi_pins_t   pins;
    results_t    res;
    logic [11:0] flags;
    logic        conv_start;
    lanes_t      lanes;
    lanes_t      lanes_oe_n;
    lanes_t      oe_seen;
    logic [11:0] cfg1;
    logic [11:0] cfg2;
    logic [79:0] ra, rb, rc, rd;
    logic [11:0] rv;
    logic [15:0] wd;
    int          failures, samples_checked, starts, frames;
    row_t rows [7] = '{'{LANES_QUAD, 1'b0, 1'b0, 16}, '{LANES_QUAD, 1'b1, 1'b0, 24},
                       '{LANES_QUAD, 1'b1, 1'b1, 26}, '{LANES_DUAL, 1'b0, 1'b0, 32},
                       '{LANES_DUAL, 1'b1, 1'b1, 44}, '{LANES_ONE, 1'b1, 1'b0, 72},
                       '{2'h3, 1'b0, 1'b1, 72}};
    wc_t wcs [7] = '{'{ADDR_CFG1, 12'h030, 2'h2, 12'h010, 12'h200},
                     '{ADDR_CFG1, 12'h030, 2'h1, 12'h030, 12'h200},
                     '{ADDR_CFG2, 12'h100, 2'h0, 12'h030, 12'h200},
                     '{ADDR_CFG2, 12'h100, 2'h2, 12'h030, 12'h200},
                     '{ADDR_CFG2, 12'h100, 2'h1, 12'h030, 12'h100},
                     '{ADDR_CFG1, 12'h010, 2'h0, 12'h030, 12'h100},
                     '{ADDR_CFG1, 12'h000, 2'h1, 12'h000, 12'h100}};

    quad_adc_serial_port_crc uut (.clk(clk), .rst_n(rst_n), .pins(pins),
        .conversion_result(res), .range_flags(flags), .conv_start(conv_start),
        .lanes(lanes), .lanes_oe_n(lanes_oe_n), .first_config_register(cfg1),
        .second_config_register(cfg2));
    host_spi_model host (.pins(pins), .lanes(lanes));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) if (conv_start === 1'b1) starts++;
    // Last enables seen while selected, settled mid-cycle
    always @(negedge clk) if (pins.cs_n === 1'b0) oe_seen <= lanes_oe_n;

    // ------------------------------------------------------------------
    // Reference arithmetic and compares
    // ------------------------------------------------------------------
    // Long division of the top n bits, top byte inverted, eight zeros appended
    function automatic logic [7:0] crc_ref(input logic [79:0] d, input int n);
        logic [87:0] r;
        r = {d ^ {8'hff, 72'h0}, 8'h00};
        for (int i = 87; i >= 88 - n; i--) if (r[i]) r[i -: 9] ^= 9'h107;
        return r[87 - n -: 8];
    endfunction

    function automatic logic [79:0] lane_exp(input results_t r, input logic [1:0] m,
                                             input logic cr, input logic bst, input int ln);
        logic [17:0] ch [4];
        logic [79:0] all, acc;
        int          w, pos;
        ch = '{r.a, r.b, r.c, r.d};
        w = bst ? 18 : 16;
        all = '0;
        for (int k = 0; k < 4; k++) begin
            if (!bst) ch[k] = {ch[k][17:2], 2'b00};
            all |= {ch[k], 62'h0} >> (k * w);
        end
        if (m == LANES_QUAD) begin
            acc = {ch[ln], 62'h0};
            pos = w;
        end else if (m == LANES_DUAL) begin
            acc = {ch[ln], 62'h0} | ({ch[ln + 2], 62'h0} >> w);
            pos = 2 * w;
        end else begin
            acc = all;
            pos = 4 * w;
        end
        if (ln == 0 && cr) acc |= {crc_ref(all, 4 * w), 72'h0} >> pos;
        return acc;
    endfunction

    task automatic check_stream(input string what, input logic [79:0] e, input logic [79:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_word(input string what, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Frame helpers
    // ------------------------------------------------------------------
    task automatic frame(input logic [23:0] tx, input int n);
        // Start off the sampling edge so the synchroniser never races the pin
        @(posedge clk);
        #1;
        host.xfer(tx, n, ra, rb, rc, rd);
        frames++;
        #300;
        check_word("lanes_oe_n idle", 12'h00f, {8'h00, lanes_oe_n});
    endtask

    // kind 0: plain 16 bits, 1: good checksum, 2: corrupted checksum
    task automatic wr(input logic [2:0] ad, input logic [11:0] dat, input logic [1:0] kind);
        logic [7:0] c;
        c = crc_ref({1'b1, ad, dat, 64'h0}, 16);
        frame({1'b1, ad, dat, (kind == 2'h2) ? ~c : c}, (kind == 2'h0) ? 16 : 24);
    endtask

    task automatic check_lanes(input results_t r, input logic [1:0] m, input logic cr,
                               input logic bst, input int n);
        check_word("lanes_oe_n busy", {8'h00, (m == LANES_QUAD) ? 4'h0 :
                   (m == LANES_DUAL) ? 4'h3 : 4'h7}, {8'h00, oe_seen});
        check_stream("lane a", lane_exp(r, m, cr, bst, 0), ra << (80 - n));
        if (m == LANES_QUAD || m == LANES_DUAL)
            check_stream("lane b", lane_exp(r, m, cr, bst, 1), rb << (80 - n));
        if (m == LANES_QUAD) begin
            check_stream("lane c", lane_exp(r, m, cr, bst, 2), rc << (80 - n));
            check_stream("lane d", lane_exp(r, m, cr, bst, 3), rd << (80 - n));
        end
    endtask

    initial begin
        for (int i = 0; i < 100000; i++) @(posedge clk);
        failures++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        res = '{18'h2_aaa9, 18'h1_5556, 18'h2_aaab, 18'h1_5554};
        flags = 12'ha5c;
        repeat (16) @(posedge clk);
        check_word("reset oe", 12'h00f, {8'h00, lanes_oe_n});
        check_word("reset cfg1", 12'h000, cfg1);
        check_word("reset cfg2", 12'h000, cfg2);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        // Lane routing, clock counts and read checksum per mode
        foreach (rows[i]) begin
            wr(ADDR_CFG2, {2'h0, rows[i].mode, 8'h00}, 2'h0);
            wr(ADDR_CFG1, {7'h00, rows[i].cr, 1'b0, rows[i].bst, 2'h0}, 2'h0);
            check_word("cfg2", {2'h0, rows[i].mode, 8'h00}, cfg2);
            frame(24'h00_0000, rows[i].n);
            check_lanes(res, rows[i].mode, rows[i].cr, rows[i].bst, rows[i].n);
        end
        // Latency: previous frame's conversion, then the fresh one
        wr(ADDR_CFG2, 12'h200, 2'h0);
        wr(ADDR_CFG1, 12'h000, 2'h0);
        @(posedge clk);
        #1 res = '{18'h0_1234, 18'h3_0f0f, 18'h1_8001, 18'h2_4c4c};
        frame(24'h00_0000, 16);
        check_lanes('{18'h2_aaa9, 18'h1_5556, 18'h2_aaab, 18'h1_5554},
                    LANES_QUAD, 1'b0, 1'b0, 16);
        @(posedge clk);
        #1 res = '{18'h1_1111, 18'h2_2222, 18'h3_3333, 18'h0_4444};
        frame(24'h00_0000, 16);
        check_lanes('{18'h0_1234, 18'h3_0f0f, 18'h1_8001, 18'h2_4c4c},
                    LANES_QUAD, 1'b0, 1'b0, 16);
        // Register reads over every address, junk in the low bits
        wr(ADDR_CFG1, 12'h010, 2'h0);
        for (int ad = 0; ad < 8; ad++) begin
            frame({1'b0, 3'(ad), 12'hfff, 8'h00}, 16);
            frame(24'h00_0000, 24);
            rv = (ad == 1) ? 12'h010 : (ad == 2) ? 12'h200 : (ad == 3) ? flags :
                 (ad == 4) ? 12'h800 : 12'h7ff;
            wd = {1'b0, 3'(ad), rv};
            if (ad >= 1 && ad <= 5)
                check_stream("read data", {wd, crc_ref({wd, 64'h0}, 16), 56'h0}, ra << 56);
            else
                check_lanes(res, LANES_QUAD, 1'b1, 1'b0, 24);
        end
        // Checked writes: enable, refuse, accept, disable
        foreach (wcs[i]) begin
            wr(wcs[i].ad, wcs[i].dat, wcs[i].kind);
            check_word("cfg1", wcs[i].c1, cfg1);
            check_word("cfg2", wcs[i].c2, cfg2);
        end
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        check_word("cfg2 after reset", 12'h000, cfg2);
        check_word("conv_start count", 12'(frames), 12'(starts));
        finish_test();
    end
endmodule // tb_quad_adc_serial_port_crc
